//--- core/l2_parity_pkg.sv
// Purpose: Shared constants and types for the level-2 data RAM parity checker.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes:   Offsets are byte addresses.
package l2_parity_pkg;

    localparam int unsigned DATA_W   = 256;
    localparam int unsigned PARITY_W = 32;
    localparam int unsigned LAT_W    = 3;
    localparam int unsigned FLAG_W   = 2;
    localparam int unsigned COUNT_W  = 16;

    localparam logic [11:0] AUX_CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] DATA_LAT_OFFSET   = 12'h004;
    localparam logic [11:0] RAW_STATUS_OFFSET = 12'h008;
    localparam logic [11:0] MASKED_OFFSET     = 12'h00C;
    localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h010;
    localparam logic [11:0] SYNDROME_OFFSET   = 12'h014;
    localparam logic [11:0] FAULT_CNT_OFFSET  = 12'h018;
    localparam logic [11:0] CHECK_CNT_OFFSET  = 12'h01C;

    localparam int unsigned PARITY_EN_BIT = 21;
    localparam int unsigned LAT_LSB       = 4;
    localparam int unsigned FLAG_LSB      = 6;

    localparam logic              PARITY_EN_RESET = 1'b0;
    localparam logic [LAT_W-1:0]  LAT_RESET       = 3'h0;
    localparam logic [FLAG_W-1:0] MASK_RESET      = 2'h0;

    // System interrupt controller line that the parity interrupt feeds.
    localparam int unsigned PARITY_IRQ_NUMBER = 125;

    typedef enum logic [3:0] {
        REG_AUX_CTRL,
        REG_DATA_LAT,
        REG_RAW_STATUS,
        REG_MASKED,
        REG_IRQ_MASK,
        REG_SYNDROME,
        REG_FAULT_CNT,
        REG_CHECK_CNT,
        REG_NONE
    } reg_sel_t;

    typedef struct packed {
        logic [DATA_W-1:0]   cache_read_word;
        logic [PARITY_W-1:0] stored_parity_word;
    } ram_return_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

//--- core/parity_compare.sv
// Purpose: Per-byte parity compare of a data RAM read word.
// Assumes: One stored parity bit for each byte of the read word.
// Notes:   Purely combinational; the caller decides when to sample it.
`timescale 1ns/1ps
`default_nettype none
module parity_compare #(
    parameter int unsigned DATA_W   = l2_parity_pkg::DATA_W,
    parameter int unsigned PARITY_W = l2_parity_pkg::PARITY_W
) (
    input  wire logic [DATA_W-1:0]   data,
    input  wire logic [PARITY_W-1:0] parity,
    input  wire logic                odd_parity,
    output logic      [PARITY_W-1:0] mismatch
);
    localparam int unsigned LANE_W = DATA_W / PARITY_W;

    genvar g;
    generate
        for (g = 0; g < PARITY_W; g++) begin : g_lane
            assign mismatch[g] = (^data[g*LANE_W +: LANE_W]) ^ odd_parity
                                 ^ parity[g];
        end
    endgenerate
endmodule
`default_nettype wire

//--- core/sticky_status.sv
// Purpose: Sticky event bits with write-one-to-clear, mask and one level irq.
// Assumes: Set and clear may arrive in the same cycle.
// Notes:   A set in the clear cycle wins, so no event is lost.
`timescale 1ns/1ps
`default_nettype none
module sticky_status #(
    parameter int unsigned W = l2_parity_pkg::FLAG_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic         clear_we,
    input  wire logic [W-1:0] clear_bits,
    input  wire logic [W-1:0] mask,
    output logic      [W-1:0] raw,
    output logic      [W-1:0] masked,
    output logic              irq
);
    logic [W-1:0] next_raw;

    always_comb begin
        next_raw = raw;
        if (clear_we) begin
            next_raw = next_raw & ~clear_bits;
        end
        next_raw = next_raw | set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw <= '0;
        end else begin
            raw <= next_raw;
        end
    end

    assign masked = raw & mask;
    assign irq    = |masked;
endmodule
`default_nettype wire

//--- core/l2_data_ram_parity_check.sv
// Purpose: Data RAM parity checker of a level-2 cache controller with APB
//          control and status registers and one parity interrupt.
// Assumes: read_req pulses in the cycle a data RAM read is launched; the
//          word and its parity return latency+1 cycles later.
// Notes:   Reads may be issued back to back; each is checked once.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Check parity only while enable bit 21 set.
// - Enable bit resets to zero, checking off.
// - Compare 256-bit word against 32 parity bits.
// - Mismatch shows in raw and masked status.
// - Read latency from bits 6:4 adds waits.
// - Sample compare only in the valid cycle.
// - Fault flags at bits 7:6 drive interrupt.
module l2_data_ram_parity_check #(
    parameter int unsigned LAT_W   = l2_parity_pkg::LAT_W,
    parameter int unsigned COUNT_W = l2_parity_pkg::COUNT_W
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           read_req,
    input  wire l2_parity_pkg::ram_return_t     ram_return,
    output logic                                check_strobe,
    output logic      [l2_parity_pkg::FLAG_W-1:0] parity_fault_flags,
    output logic                                parity_irq
);
    localparam int unsigned DEPTH = 1 << LAT_W;
    localparam int unsigned FW    = l2_parity_pkg::FLAG_W;
    localparam int unsigned PW    = l2_parity_pkg::PARITY_W;
    localparam int unsigned HALF  = PW / 2;

    l2_parity_pkg::apb_req_t req;
    l2_parity_pkg::reg_sel_t sel;

    logic              parity_en;
    logic [LAT_W-1:0]  latency;
    logic [FW-1:0]     irq_mask;
    logic [FW-1:0]     raw_status;
    logic [FW-1:0]     masked_status;
    logic [PW-1:0]     syndrome;
    logic [COUNT_W-1:0] fault_count;
    logic [COUNT_W-1:0] check_count;
    logic [DEPTH-1:0]  pending;
    logic [PW-1:0]     lane_mismatch;
    logic              check_now;
    logic [FW-1:0]     fault_set;
    logic              wr_strobe;
    logic              setup_phase;

    // Maps a byte address to the register it selects.
    function automatic l2_parity_pkg::reg_sel_t decode(input logic [11:0] a);
        case (a)
            l2_parity_pkg::AUX_CTRL_OFFSET:   decode = l2_parity_pkg::REG_AUX_CTRL;
            l2_parity_pkg::DATA_LAT_OFFSET:   decode = l2_parity_pkg::REG_DATA_LAT;
            l2_parity_pkg::RAW_STATUS_OFFSET: decode = l2_parity_pkg::REG_RAW_STATUS;
            l2_parity_pkg::MASKED_OFFSET:     decode = l2_parity_pkg::REG_MASKED;
            l2_parity_pkg::IRQ_MASK_OFFSET:   decode = l2_parity_pkg::REG_IRQ_MASK;
            l2_parity_pkg::SYNDROME_OFFSET:   decode = l2_parity_pkg::REG_SYNDROME;
            l2_parity_pkg::FAULT_CNT_OFFSET:  decode = l2_parity_pkg::REG_FAULT_CNT;
            l2_parity_pkg::CHECK_CNT_OFFSET:  decode = l2_parity_pkg::REG_CHECK_CNT;
            default:                          decode = l2_parity_pkg::REG_NONE;
        endcase
    endfunction

    assign req.psel    = psel;
    assign req.penable = penable;
    assign req.pwrite  = pwrite;
    assign req.paddr   = paddr;
    assign req.pwdata  = pwdata;

    assign sel         = decode(req.paddr);
    assign setup_phase = req.psel && !req.penable;
    assign wr_strobe   = req.psel && req.penable && req.pwrite;

    // The slave never stretches a transfer; read data is ready from setup.
    assign pready  = 1'b1;
    assign pslverr = req.psel && req.penable
                     && (sel == l2_parity_pkg::REG_NONE);

    // Control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_en <= l2_parity_pkg::PARITY_EN_RESET;
            latency   <= l2_parity_pkg::LAT_RESET;
            irq_mask  <= l2_parity_pkg::MASK_RESET;
        end else if (wr_strobe) begin
            case (sel)
                l2_parity_pkg::REG_AUX_CTRL: begin
                    parity_en <= req.pwdata[l2_parity_pkg::PARITY_EN_BIT];
                end
                l2_parity_pkg::REG_DATA_LAT: begin
                    latency <= req.pwdata[l2_parity_pkg::LAT_LSB +: LAT_W];
                end
                l2_parity_pkg::REG_IRQ_MASK: begin
                    irq_mask <= req.pwdata[l2_parity_pkg::FLAG_LSB +: FW];
                end
                default: begin
                end
            endcase
        end
    end

    // Each launched read walks down this line; bit k means k+1 cycles ago.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= '0;
        end else begin
            pending <= {pending[DEPTH-2:0], read_req};
        end
    end

    // Only the tap that matches the programmed latency is looked at, so the
    // cycle before the data settles is never sampled.
    assign check_now    = pending[latency] && parity_en;
    assign check_strobe = check_now;

    parity_compare #(
        .DATA_W   (l2_parity_pkg::DATA_W),
        .PARITY_W (PW)
    ) u_compare (
        .data       (ram_return.cache_read_word),
        .parity     (ram_return.stored_parity_word),
        .odd_parity (1'b0),
        .mismatch   (lane_mismatch)
    );

    // Low flag covers the lower half of the word, high flag the upper half.
    assign fault_set = check_now
                       ? {|lane_mismatch[PW-1:HALF], |lane_mismatch[HALF-1:0]}
                       : '0;

    sticky_status #(
        .W (FW)
    ) u_status (
        .pclk       (pclk),
        .presetn    (presetn),
        .set        (fault_set),
        .clear_we   (wr_strobe && (sel == l2_parity_pkg::REG_RAW_STATUS)),
        .clear_bits (req.pwdata[l2_parity_pkg::FLAG_LSB +: FW]),
        .mask       (irq_mask),
        .raw        (raw_status),
        .masked     (masked_status),
        .irq        (parity_irq)
    );

    assign parity_fault_flags = raw_status;

    // Lane pattern of the most recent failing check.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            syndrome <= '0;
        end else if (|fault_set) begin
            syndrome <= lane_mismatch;
        end
    end

    // Saturating fault counter; a write clears it, or loads one if a fault lands in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_count <= '0;
        end else if (|fault_set) begin
            if (wr_strobe && (sel == l2_parity_pkg::REG_FAULT_CNT)) begin
                fault_count <= COUNT_W'(1);
            end else if (fault_count != '1) begin
                fault_count <= fault_count + COUNT_W'(1);
            end
        end else if (wr_strobe && (sel == l2_parity_pkg::REG_FAULT_CNT)) begin
            fault_count <= '0;
        end
    end

    // Saturating count of checks performed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            check_count <= '0;
        end else if (check_now) begin
            if (wr_strobe && (sel == l2_parity_pkg::REG_CHECK_CNT)) begin
                check_count <= COUNT_W'(1);
            end else if (check_count != '1) begin
                check_count <= check_count + COUNT_W'(1);
            end
        end else if (wr_strobe && (sel == l2_parity_pkg::REG_CHECK_CNT)) begin
            check_count <= '0;
        end
    end

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_phase && !req.pwrite) begin
            prdata <= '0;
            case (sel)
                l2_parity_pkg::REG_AUX_CTRL: begin
                    prdata[l2_parity_pkg::PARITY_EN_BIT] <= parity_en;
                end
                l2_parity_pkg::REG_DATA_LAT: begin
                    prdata[l2_parity_pkg::LAT_LSB +: LAT_W] <= latency;
                end
                l2_parity_pkg::REG_RAW_STATUS: begin
                    prdata[l2_parity_pkg::FLAG_LSB +: FW] <= raw_status;
                end
                l2_parity_pkg::REG_MASKED: begin
                    prdata[l2_parity_pkg::FLAG_LSB +: FW] <= masked_status;
                end
                l2_parity_pkg::REG_IRQ_MASK: begin
                    prdata[l2_parity_pkg::FLAG_LSB +: FW] <= irq_mask;
                end
                l2_parity_pkg::REG_SYNDROME: begin
                    prdata <= syndrome;
                end
                l2_parity_pkg::REG_FAULT_CNT: begin
                    prdata[COUNT_W-1:0] <= fault_count;
                end
                l2_parity_pkg::REG_CHECK_CNT: begin
                    prdata[COUNT_W-1:0] <= check_count;
                end
                default: begin
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- tb/l2_parity_check_sva.sv
// Purpose: Port assertions for the data RAM parity checker.
// Assumes: Latency is reprogrammed only while no read is in flight.
// Notes:   Control fields are mirrored from completed APB writes.
`timescale 1ns/1ps
`default_nettype none
module l2_parity_check_sva (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       read_req,
    input wire l2_parity_pkg::ram_return_t ram_return,
    input wire logic                       check_strobe,
    input wire logic [1:0]                 parity_fault_flags,
    input wire logic                       parity_irq
);
    logic       wr;
    logic       en;
    logic [2:0] lat;
    logic [1:0] mask;
    logic [7:0] hist;
    assign wr = psel && penable && pwrite && pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en   <= 1'b0;
            lat  <= 3'h0;
            mask <= 2'h0;
        end else if (wr) begin
            if (paddr == l2_parity_pkg::AUX_CTRL_OFFSET) en <= pwdata[21];
            if (paddr == l2_parity_pkg::DATA_LAT_OFFSET) lat <= pwdata[6:4];
            if (paddr == l2_parity_pkg::IRQ_MASK_OFFSET) mask <= pwdata[7:6];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= 8'h00;
        end else begin
            hist <= {hist[6:0], read_req};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_strobe_when: assert property (check_strobe |-> en && hist[lat])
        else $error("check outside the valid cycle");
    chk_each_read: assert property (en && hist[lat] |-> check_strobe)
        else $error("read left unchecked");
    chk_flag_cause: assert property (
        |(parity_fault_flags & ~$past(parity_fault_flags))
        |-> $past(check_strobe))
        else $error("flag set without a check");
    chk_flag_sticky: assert property (
        |($past(parity_fault_flags) & ~parity_fault_flags)
        |-> $past(wr && paddr == l2_parity_pkg::RAW_STATUS_OFFSET))
        else $error("flag dropped without a clear");
    chk_clear_slot: assert property (
        wr && paddr == l2_parity_pkg::RAW_STATUS_OFFSET && !check_strobe
        |=> (parity_fault_flags & $past(pwdata[7:6])) == 2'h0)
        else $error("write one did not clear");
    chk_irq_mask: assert property (
        parity_irq == |(parity_fault_flags & mask))
        else $error("irq differs from masked flags");
    chk_reset_clean: assert property (
        $rose(presetn) |-> parity_fault_flags == 2'h0 && !parity_irq)
        else $error("state not clean after reset");
    chk_bad_addr: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > l2_parity_pkg::CHECK_CNT_OFFSET))
        else $error("error response wrong");
endmodule
bind l2_data_ram_parity_check l2_parity_check_sva chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .read_req(read_req),
    .ram_return(ram_return), .check_strobe(check_strobe),
    .parity_fault_flags(parity_fault_flags), .parity_irq(parity_irq));
`default_nettype wire

//--- tb/ram_model.sv
// Purpose: Data and parity RAM arrays answering reads after the latency.
// Assumes: bad flips stored parity bits 0 and 16 of the read launched.
// Notes:   Outside the valid cycle the lines invert every cycle.
`timescale 1ns/1ps
`default_nettype none
module ram_model (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      read_req,
    input  wire logic [2:0]                lat,
    input  wire logic [1:0]                bad,
    output var  l2_parity_pkg::ram_return_t ram_return
);
    l2_parity_pkg::ram_return_t q[$];
    l2_parity_pkg::ram_return_t r;
    logic [7:0]                 vld;
    int                         s = 31284;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vld = 8'h00;
            q.delete();
            ram_return <= '0;
        end else begin
            if (read_req) begin
                for (int k = 0; k < 8; k++)
                    r.cache_read_word[32*k+:32] = $random(s);
                for (int i = 0; i < 32; i++)
                    r.stored_parity_word[i] = ^r.cache_read_word[8*i+:8];
                r.stored_parity_word[0] = r.stored_parity_word[0] ^ bad[0];
                r.stored_parity_word[16] = r.stored_parity_word[16] ^ bad[1];
                q.push_back(r);
            end
            vld = {vld[6:0], read_req};
            if (vld[lat]) ram_return <= q.pop_front();
            else ram_return <= ~ram_return;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the data RAM parity checker.
// Assumes: APB reads are compared by a monitor against queued notes.
// Notes:   The RAM model supplies the word; bad corrupts its parity.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, check_strobe, parity_irq, read_req = 0;
    logic [1:0] flags, bad = 0, b, ef;
    logic [2:0] lat = 0;
    l2_parity_pkg::ram_return_t ram_return;
    logic [32:0] exp_q[$];
    int fails = 0, n_compared = 0, seed = 31284, nf;
    always #10 pclk = ~pclk;
    l2_data_ram_parity_check dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .read_req(read_req), .ram_return(ram_return),
        .check_strobe(check_strobe), .parity_fault_flags(flags),
        .parity_irq(parity_irq));
    ram_model ram (.pclk(pclk), .presetn(presetn), .read_req(read_req),
        .lat(lat), .bad(bad), .ram_return(ram_return));
    task automatic chk(input string nm, input logic [32:0] e, g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input [11:0] a, input [31:0] e, input se = 0);
        exp_q.push_back({se, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic rq(input logic [1:0] v);
        @(posedge pclk);
        read_req <= 1'b1;
        bad <= v;
        @(posedge pclk);
        read_req <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("read", exp_q.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        #1000000;
        fails++;
        results();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(l2_parity_pkg::AUX_CTRL_OFFSET, 32'h0);
        rd(l2_parity_pkg::DATA_LAT_OFFSET, 32'h0);
        rd(l2_parity_pkg::IRQ_MASK_OFFSET, 32'h0);
        rd(12'h020, 32'h0, 1'b1);
        rq(2'h3);
        rd(l2_parity_pkg::RAW_STATUS_OFFSET, 32'h0);
        apb(1'b1, l2_parity_pkg::AUX_CTRL_OFFSET, 32'h0020_0000);
        apb(1'b1, l2_parity_pkg::IRQ_MASK_OFFSET, 32'h0000_00C0);
        for (int l = 0; l < 8; l++) begin
            apb(1'b1, l2_parity_pkg::DATA_LAT_OFFSET, 32'(l) << 4);
            lat <= 3'(l);
            rq(2'h0);
            rd(l2_parity_pkg::RAW_STATUS_OFFSET, 32'h0);
            rq(l[0] ? 2'h1 : 2'h2);
            rd(l2_parity_pkg::RAW_STATUS_OFFSET, l[0] ? 32'h40 : 32'h80);
            chk("irq", 33'h1, {32'h0, parity_irq});
            rd(l2_parity_pkg::SYNDROME_OFFSET, l[0] ? 32'h1 : 32'h1_0000);
            apb(1'b1, l2_parity_pkg::RAW_STATUS_OFFSET, 32'h0000_00C0);
            rd(l2_parity_pkg::RAW_STATUS_OFFSET, 32'h0);
        end
        apb(1'b1, l2_parity_pkg::IRQ_MASK_OFFSET, 32'h0);
        rq(2'h2);
        rd(l2_parity_pkg::MASKED_OFFSET, 32'h0);
        chk("irq", 33'h0, {32'h0, parity_irq});
        apb(1'b1, l2_parity_pkg::IRQ_MASK_OFFSET, 32'h0000_0080);
        rd(l2_parity_pkg::MASKED_OFFSET, 32'h80);
        apb(1'b1, l2_parity_pkg::RAW_STATUS_OFFSET, 32'h0000_00C0);
        apb(1'b1, l2_parity_pkg::FAULT_CNT_OFFSET, 32'h0);
        apb(1'b1, l2_parity_pkg::CHECK_CNT_OFFSET, 32'h0);
        ef = 2'h0;
        nf = 0;
        for (int i = 0; i < 20; i++) begin
            b = 2'($random(seed));
            read_req <= 1'b1;
            bad <= b;
            ef = ef | b;
            nf += int'(b != 2'h0);
            @(posedge pclk);
        end
        read_req <= 1'b0;
        repeat (12) @(posedge pclk);
        rd(l2_parity_pkg::RAW_STATUS_OFFSET, {24'h0, ef, 6'h0});
        rd(l2_parity_pkg::FAULT_CNT_OFFSET, 32'(nf));
        rd(l2_parity_pkg::CHECK_CNT_OFFSET, 32'd20);
        apb(1'b1, l2_parity_pkg::AUX_CTRL_OFFSET, 32'h0);
        rq(2'h3);
        rd(l2_parity_pkg::CHECK_CNT_OFFSET, 32'd20);
        results();
    end
endmodule
`default_nettype wire
